// ===== rtl/wbc_data_cache.sv
// direct-mapped write-back data cache with miss controller and snoop port
//
// What this block does
// - direct-mapped write-back cache, 32 blocks of 4 words (128 words)
// - address fields match the instruction cache
// - tag 25 bits, index 5, word offset 2
// - one dirty flag per block, written back
// - second independent read port for arbiter lookups
// - snoop lookups never disturb cache or controller
// - on miss stall, write back a dirty block, then fetch
// - leave idle only on a miss
// - dirty goes to write-back, else fetch
// - each loop moves exactly four words
// - every word goes through the arbiter
// - fully interlocked two-line request/acknowledge handshake
// - stall held throughout miss, dropped at idle
`timescale 1ns/1ps
`default_nettype none
module wbc_data_cache (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_load_request_line,
  input wire logic i_store_request_line,
  input wire logic [wbc_pkg::ADDR_W-1:0] i_first_operand_reg,
  input wire logic [wbc_pkg::DATA_W-1:0] i_second_operand_reg,
  output logic [wbc_pkg::DATA_W-1:0] o_load_data,
  output logic o_stall_data,
  output logic o_sram_req,
  output logic o_sram_we,
  output logic [wbc_pkg::ADDR_W-1:0] o_sram_addr,
  output logic [wbc_pkg::DATA_W-1:0] o_sram_wdata,
  input wire logic i_sram_ack,
  input wire logic [wbc_pkg::DATA_W-1:0] i_sram_rdata,
  input wire logic [wbc_pkg::ADDR_W-1:0] i_snoop_addr,
  output logic o_snoop_hit,
  output logic [wbc_pkg::DATA_W-1:0] o_snoop_data
);
  import wbc_pkg::*;

  // ********************************
  // storage
  // ********************************
  // flip-flop arrays give two asynchronous read ports for free
  logic [DATA_W-1:0] core_q [NUM_BLOCKS][WORDS_PER_BLOCK];
  logic [TAG_W-1:0] tag_q [NUM_BLOCKS];
  logic [NUM_BLOCKS-1:0] valid_q;
  logic [NUM_BLOCKS-1:0] dirty_q;

  wbc_state_t state_q;
  logic [OFS_W-1:0] cnt_q;

  // ********************************
  // address split
  // ********************************
  logic [TAG_W-1:0] req_tag;
  logic [IDX_W-1:0] req_idx;
  logic [OFS_W-1:0] req_ofs;
  logic req_any;
  logic hit;
  assign req_tag = i_first_operand_reg[TAG_LSB +: TAG_W];
  assign req_idx = i_first_operand_reg[IDX_LSB +: IDX_W];
  assign req_ofs = i_first_operand_reg[OFS_LSB +: OFS_W];
  // both lines together do a store and a load
  assign req_any = i_load_request_line | i_store_request_line;
  assign hit = valid_q[req_idx] && (tag_q[req_idx] == req_tag);

  // ********************************
  // miss controller
  // ********************************
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= WBC_IDLE;
    end else begin
      case (state_q)
        WBC_IDLE: begin
          if (req_any && !hit) begin
            state_q <= dirty_q[req_idx] ? WBC_WB_REQ : WBC_FE_REQ;
          end
        end
        WBC_WB_REQ: begin
          if (i_sram_ack) begin
            state_q <= WBC_WB_REL;
          end
        end
        WBC_WB_REL: begin
          if (!i_sram_ack) begin
            state_q <= (cnt_q == OFS_LAST) ? WBC_FE_REQ : WBC_WB_REQ;
          end
        end
        WBC_FE_REQ: begin
          if (i_sram_ack) begin
            state_q <= WBC_FE_REL;
          end
        end
        WBC_FE_REL: begin
          if (!i_sram_ack) begin
            state_q <= (cnt_q == OFS_LAST) ? WBC_SERVE : WBC_FE_REQ;
          end
        end
        WBC_SERVE: begin
          state_q <= WBC_IDLE;
        end
        default: begin
          state_q <= WBC_IDLE;
        end
      endcase
    end
  end

  // word counter shared by both loops
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cnt_q <= OFS_FIRST;
    end else if ((state_q == WBC_WB_REL || state_q == WBC_FE_REL) && !i_sram_ack) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  // ********************************
  // arbiter client port
  // ********************************
  // address/data are registered so they stand steady while the request is up
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_sram_req <= 1'b0;
      o_sram_we <= 1'b0;
      o_sram_addr <= '0;
      o_sram_wdata <= '0;
    end else begin
      case (state_q)
        WBC_WB_REQ: begin
          o_sram_req <= !i_sram_ack;
          o_sram_we <= 1'b1;
          o_sram_addr <= {tag_q[req_idx], req_idx, cnt_q};
          o_sram_wdata <= core_q[req_idx][cnt_q];
        end
        WBC_FE_REQ: begin
          o_sram_req <= !i_sram_ack;
          o_sram_we <= 1'b0;
          o_sram_addr <= {req_tag, req_idx, cnt_q};
        end
        default: begin
          o_sram_req <= 1'b0;
          o_sram_we <= 1'b0;
        end
      endcase
    end
  end

  // ********************************
  // storage update
  // ********************************
  always_ff @(posedge i_mclk) begin
    if (state_q == WBC_FE_REQ && i_sram_ack) begin
      core_q[req_idx][cnt_q] <= i_sram_rdata;
    end else if (i_store_request_line && hit && state_q != WBC_FE_REQ
                 && state_q != WBC_FE_REL) begin
      core_q[req_idx][req_ofs] <= i_second_operand_reg;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (state_q == WBC_FE_REL && !i_sram_ack && cnt_q == OFS_LAST) begin
      tag_q[req_idx] <= req_tag;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      valid_q <= '0;
      dirty_q <= '0;
    end else if (state_q == WBC_FE_REL && !i_sram_ack && cnt_q == OFS_LAST) begin
      valid_q[req_idx] <= 1'b1;
      dirty_q[req_idx] <= 1'b0;
    end else if (i_store_request_line && hit
                 && (state_q == WBC_IDLE || state_q == WBC_SERVE)) begin
      dirty_q[req_idx] <= 1'b1;
    end
  end

  // ********************************
  // processor side
  // ********************************
  // stall rises the cycle after a miss is seen and falls on return to idle
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_stall_data <= 1'b0;
    end else if (state_q == WBC_IDLE) begin
      o_stall_data <= req_any && !hit;
    end else begin
      o_stall_data <= state_q != WBC_SERVE;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_load_data <= '0;
    end else if (i_load_request_line && hit) begin
      o_load_data <= core_q[req_idx][req_ofs];
    end
  end

  // ********************************
  // snoop port
  // ********************************
  // reads only; no path back into the controller
  logic [IDX_W-1:0] snp_idx;
  assign snp_idx = i_snoop_addr[IDX_LSB +: IDX_W];
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_snoop_hit <= 1'b0;
      o_snoop_data <= '0;
    end else begin
      o_snoop_hit <= valid_q[snp_idx]
                     && tag_q[snp_idx] == i_snoop_addr[TAG_LSB +: TAG_W];
      o_snoop_data <= core_q[snp_idx][i_snoop_addr[OFS_LSB +: OFS_W]];
    end
  end
endmodule
`default_nettype wire

// ===== rtl/wbc_pkg.sv
// package for the write-back data cache controller
`default_nettype none
package wbc_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int TAG_W = 25;
  localparam int IDX_W = 5;
  localparam int OFS_W = 2;
  localparam int TAG_LSB = 7;
  localparam int IDX_LSB = 2;
  localparam int OFS_LSB = 0;
  localparam int WORDS_PER_BLOCK = 4;
  localparam int CACHE_WORDS = 32;
  localparam int NUM_BLOCKS = 32;
  localparam logic [OFS_W-1:0] OFS_LAST = 2'h3;
  localparam logic [OFS_W-1:0] OFS_FIRST = 2'h0;
  typedef enum logic [2:0] {
    WBC_IDLE,
    WBC_WB_REQ,
    WBC_WB_REL,
    WBC_FE_REQ,
    WBC_FE_REL,
    WBC_SERVE
  } wbc_state_t;
endpackage
`default_nettype wire

// ===== tb/wbc_data_cache_assertions.sv
// handshake and stall checks for the data cache
`timescale 1ns/1ps
`default_nettype none
module wbc_chk (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic o_stall_data,
  input wire logic o_sram_req,
  input wire logic [31:0] o_sram_addr,
  input wire logic i_sram_ack
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  sequence s_word;
    o_sram_req ##[1:20] !o_sram_req;
  endsequence
  req_hold_a: assert property (o_sram_req && !i_sram_ack |=>
    o_sram_req && $stable(o_sram_addr)) else $error("req not held");
  req_drop_a: assert property (o_sram_req && i_sram_ack |=> !o_sram_req)
    else $error("req not dropped");
  rel_wait_a: assert property (!o_sram_req && i_sram_ack |=> !o_sram_req)
    else $error("early next word");
  req_stall_a: assert property (o_sram_req |-> o_stall_data)
    else $error("req without stall");
  word_done_a: assert property ($rose(o_sram_req) |-> s_word)
    else $error("word hung");
  miss_start_a: assert property ($rose(o_stall_data) |-> ##[0:3] o_sram_req)
    else $error("no transfer");
  stall_hold_a: assert property ($rose(o_stall_data) |-> o_stall_data[*8])
    else $error("stall too short");
  stall_fall_a: assert property ($fell(o_stall_data) |-> !$past(o_sram_req))
    else $error("stall fell early");
endmodule
bind wbc_data_cache wbc_chk chk_u (.*);
`default_nettype wire

// ===== tb/wbc_sram_model.sv
// sram arbiter model with a settable answer delay
`timescale 1ns/1ps
`default_nettype none
module wbc_sram_model (
  input wire logic i_mclk,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic [2:0] i_wait,
  output var logic o_ack = 1'b0,
  output var logic [31:0] o_rdata = 32'h0,
  output var int o_xfers = 0
);
  logic [31:0] mem [logic [31:0]];
  int cnt = 0;
  always @(posedge i_mclk) begin
    if (!o_ack && i_req && cnt < i_wait) cnt <= cnt + 1;
    else if (!o_ack && i_req) begin
      cnt <= 0;
      o_ack <= 1'b1;
      o_xfers <= o_xfers + 1;
      if (i_we) mem[i_addr] = i_wdata;
      o_rdata <= mem.exists(i_addr) ? mem[i_addr] : ~i_addr;
    end else if (o_ack && !i_req) begin
      o_ack <= 1'b0;
      // no stale word on a released bus
      o_rdata <= ~o_rdata;
    end
  end
endmodule
`default_nettype wire

// ===== tb/test_wbc_data_cache.sv
// self-checking bench for the data cache
`timescale 1ns/1ps
`default_nettype none
module test_wbc_data_cache;
  logic clk = 0, rst_n = 0, ld = 0, st = 0, ack, stl, rq, we, hit;
  logic [31:0] a = 0, d = 0, sa = 0, r = 32'h30C74675, q, rd, sq, ra, wd;
  logic [25:0] tg [32] = '{default: 26'h0};
  logic [31:0] mem [logic [31:0]];
  bit dt [32];
  logic [2:0] wt = 0;
  int xf, fail_count = 0, checks_done = 0;
  always #50 clk = ~clk;
  wbc_data_cache dut_u (.i_mclk(clk), .i_rst_n(rst_n), .i_load_request_line(ld),
    .i_store_request_line(st), .i_first_operand_reg(a), .i_second_operand_reg(d),
    .o_load_data(q), .o_stall_data(stl), .o_sram_req(rq), .o_sram_we(we),
    .o_sram_addr(ra), .o_sram_wdata(wd), .i_sram_ack(ack), .i_sram_rdata(rd),
    .i_snoop_addr(sa), .o_snoop_hit(hit), .o_snoop_data(sq));
  wbc_sram_model sram_u (.i_mclk(clk), .i_req(rq), .i_we(we), .i_addr(ra),
    .i_wdata(wd), .i_wait(wt), .o_ack(ack), .o_rdata(rd), .o_xfers(xf));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // unwritten words read back as the inverted address
  function automatic logic [31:0] ev(input logic [31:0] x);
    return mem.exists(x) ? mem[x] : ~x;
  endfunction
  task automatic cmp(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) fail_count++;
    if (g !== e) $display("wrong value %s exp %h got %h", n, e, g);
  endtask
  task automatic print_verdict(input int extra);
    fail_count += extra;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic acc(input logic s, input logic [31:0] x, y);
    logic [4:0] i;
    logic m;
    int n;
    i = x[6:2];
    m = tg[i] !== {1'b1, x[31:7]};
    n = xf;
    st = s;
    ld = !s | r[11];
    a = x;
    d = y;
    sa = r;
    wt = r[10:8];
    repeat (2) @(negedge clk);
    cmp("stall", m, stl);
    for (int k = 0; stl !== 1'b0; k++) begin
      @(negedge clk);
      if (k > 300) print_verdict(1);
    end
    if (m) @(negedge clk);
    cmp("xfers", m ? (dt[i] ? 8 : 4) : 0, xf - n);
    if (!s) cmp("load", ev(x), q);
    if (s) mem[x] = y;
    tg[i] = {1'b1, x[31:7]};
    dt[i] = (dt[i] && !m) || s;
    st = 0;
    ld = 0;
    sa = x;
    repeat (2) @(negedge clk);
    cmp("snoop hit", 1, hit);
    cmp("snoop data", ev(x), sq);
    // another tag on the same index must not hit
    sa = x ^ 32'h80000000;
    @(negedge clk);
    cmp("snoop miss", 0, hit);
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst_n = 1;
    // dirty victim, then only the write-back can return the word
    acc(1, 32'h00000010, 32'h12345678);
    acc(1, 32'h00000090, 32'hA5A50001);
    acc(0, 32'h00000013, 32'h0);
    acc(0, 32'h00000010, 32'h0);
    acc(1, 32'hFFFFFFFF, 32'h0F0F0F0F);
    // mid-run reset drops valid and dirty; dirty data not yet written back is lost
    sa = 32'hFFFFFFFF;
    rst_n = 0;
    repeat (2) @(negedge clk);
    cmp("reset stall", 0, stl);
    cmp("reset load", 0, q);
    cmp("reset snoop", 0, hit);
    rst_n = 1;
    mem = sram_u.mem;
    tg = '{default: 26'h0};
    dt = '{default: 1'b0};
    acc(0, 32'h00000010, 32'h0);
    acc(0, 32'hFFFFFFFF, 32'h0);
    repeat (150) begin
      r = nxt(r);
      acc(r[7], {r[31], 22'h0, r[1:0], 2'h0, r[4:2], r[6:5]}, nxt(r));
    end
    print_verdict(0);
  end
endmodule
`default_nettype wire
